/* File: row_column_shift_network.v */
// shift network for row/column conversion between side buffers and memory buffer
`include "row_column_shift_map.vh"
module row_column_shift_network (
  input  wire        core_clk_i,
  input  wire        sys_rst_i,
  input  wire        mem_buf_shift_pulse_i,
  input  wire        in_buf_shift_left_pulse_i,
  input  wire        out_buf_shift_left_pulse_i,
  input  wire        input_phase_i,
  input  wire        output_phase_i,
  input  wire        convert_i,
  input  wire        mem_load_i,
  input  wire [15:0] mem_load_data_i,
  input  wire        in_load_i,
  input  wire [5:0]  in_load_data_i,
  input  wire        char_ready_i,
  output wire        char_valid_o,
  output wire [5:0]  char_data_o,
  output wire        shift_ready_o,
  output wire [15:0] memory_buffer_o,
  output wire [5:0]  output_buffer_o,
  output wire [2:0]  shift_count_mod6_o,
  output wire [2:0]  char_count_mod7_o,
  output wire        char_count_mod2_o,
  output wire [1:0]  card_group_count_mod4_o,
  output wire        second_shift_o
);

  reg [15:0] memory_buffer_reg;
  reg [5:0]  input_buffer_reg;
  reg [5:0]  output_buffer_reg;
  reg        second_r;
  reg [2:0]  shift_count_mod6;
  reg [2:0]  char_count_mod7;
  reg        char_count_mod2;
  reg [1:0]  card_group_count_mod4;
  reg [5:0]  fifo_data_r [0:1];
  reg [1:0]  fifo_cnt_r;
  reg        fifo_rd_r;

  wire       c2r_active;
  wire       r2c_active;
  wire       shift_ok;
  wire       mb_shift;
  wire       ib_shift;
  wire       ob_shift;
  wire       stage1_in;
  wire       parity_bit;
  wire       char_done;
  wire       push;
  wire       pop;
  wire [2:0] mod6_nxt;
  wire [2:0] mod7_nxt;
  wire [15:0] mem_buf_nxt;

  // the buffer-shift pulse alternates between the half swap and the
  // one-bit shift; second_r remembers which one the next pulse gives.
  // a memory load re-arms the pair so the next pulse is a swap; a shift in the same cycle wins over the load.
  // all pulses are expected from logic on this clock, so no pulse is
  // synchronised here; a pulse from another domain must be retimed first.
  // a refused pulse (full character buffer) changes nothing at all, so a
  // caller may simply hold it until shift_ready_o rises again.

  // phase gating: each conversion only in its own half of the cycle
  assign r2c_active = convert_i & input_phase_i;
  assign c2r_active = convert_i & output_phase_i;

  // a full buffer holds off all shifting so no character is lost
  assign shift_ready_o = (fifo_cnt_r != 2'h2);
  assign shift_ok = shift_ready_o;
  assign mb_shift = mem_buf_shift_pulse_i & shift_ok;
  assign ib_shift = in_buf_shift_left_pulse_i & mb_shift;
  assign ob_shift = out_buf_shift_left_pulse_i & mb_shift;

  // stage-1 source select, decoded from the concurrent side shifts;
  // every pulse mix has a case, so stage 1 is never left undefined
  function stage1_pick;
    input ob;
    input ib;
    input in_bit;
    input mem_bit;
    input out_bit;
    begin
      case ({ob, ib})
        2'h3:    stage1_pick = in_bit;
        2'h2:    stage1_pick = mem_bit;
        2'h1:    stage1_pick = out_bit;
        default: stage1_pick = 1'b0;
      endcase
    end
  endfunction

  assign stage1_in = stage1_pick(ob_shift, ib_shift,
                                 input_buffer_reg[5],
                                 memory_buffer_reg[5],
                                 output_buffer_reg[0]);

  // odd parity of three bits; kept apart so the checker's view matches
  function odd_parity3;
    input a;
    input b;
    input c;
    begin
      odd_parity3 = ~(a ^ b ^ c);
    end
  endfunction

  // parity over the entering bit and the two bits leaving the top
  assign parity_bit = odd_parity3(stage1_in, memory_buffer_reg[13],
                                  memory_buffer_reg[15]);

  // swap-and-shift: one mapping gives the swap first, one-bit shift second
  assign mem_buf_nxt = {memory_buffer_reg[7:0],
                        parity_bit,
                        memory_buffer_reg[14],
                        memory_buffer_reg[12:8],
                        stage1_in};

  // shift-counter sequences, left shift with feedback into bit 0
  function [2:0] mod6_step;
    input [2:0] v;
    begin
      mod6_step = {v[1:0], ~v[2]};
    end
  endfunction

  function [2:0] mod7_step;
    input [2:0] v;
    begin
      mod7_step = {v[1:0], ~(v[2] ^ v[0])};
    end
  endfunction

  assign mod6_nxt = mod6_step(shift_count_mod6);
  assign mod7_nxt = mod7_step(char_count_mod7);
  assign char_done = mb_shift & second_r & (shift_count_mod6 == `MOD6_LAST);

  // memory, side buffers and pair phase
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      memory_buffer_reg <= `MEM_BUF_RST;
      input_buffer_reg  <= `SIDE_BUF_RST;
      output_buffer_reg <= `SIDE_BUF_RST;
      second_r          <= 1'b0;
    end else begin
      if (mb_shift) begin
        memory_buffer_reg <= mem_buf_nxt;
        second_r          <= ~second_r;
      end else if (mem_load_i) begin
        memory_buffer_reg <= mem_load_data_i;
        second_r          <= 1'b0;
      end
      // input buffer steps left only on the one-bit shift of the input phase
      if (ib_shift & second_r & r2c_active)
        input_buffer_reg <= {input_buffer_reg[4:0], 1'b0};
      else if (in_load_i)
        input_buffer_reg <= in_load_data_i;
      // stage 14 leaves on the swap shift only
      if (ob_shift & ~second_r & c2r_active)
        output_buffer_reg <= {output_buffer_reg[4:0], memory_buffer_reg[13]};
    end
  end

  // character and group counters; only the pair-completing shift counts a bit
  // mod6 and mod7 are shift counters instead of binary ones: each step is a left shift with
  // one feedback bit, which keeps the decode of every state to a few gates.
  // the counters are not cleared by a memory load: a row keeps its count
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      shift_count_mod6      <= `MOD6_RST;
      char_count_mod7       <= `MOD7_RST;
      char_count_mod2       <= 1'b0;
      card_group_count_mod4 <= 2'h0;
    end else if (mb_shift & second_r) begin
      shift_count_mod6 <= mod6_nxt;
      if (char_done) begin
        if (char_count_mod7 == `MOD7_LAST) begin
          char_count_mod7 <= `MOD7_RST;
          char_count_mod2 <= ~char_count_mod2;
          if (char_count_mod2)
            card_group_count_mod4 <= card_group_count_mod4 + 2'h1;
        end else begin
          char_count_mod7 <= mod7_nxt;
        end
      end
    end
  end

  // two-entry buffer toward the punch buffer; receiver stall holds it
  // push and pop may fall in one cycle; the count then stays put while
  // both pointers move. a push into a full buffer cannot happen, since a
  // full buffer refuses the shift that would complete the character.
  assign push = char_done & c2r_active;
  assign pop  = char_valid_o & char_ready_i;
  assign char_valid_o = (fifo_cnt_r != 2'h0);
  assign char_data_o  = fifo_data_r[fifo_rd_r];

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      fifo_cnt_r     <= 2'h0;
      fifo_rd_r      <= 1'b0;
      fifo_data_r[0] <= `SIDE_BUF_RST;
      fifo_data_r[1] <= `SIDE_BUF_RST;
    end else begin
      if (push)  // last bit joins the character as it is written
        fifo_data_r[fifo_rd_r ^ fifo_cnt_r[0]] <=
          {output_buffer_reg[4:0], memory_buffer_reg[13]};
      if (pop)
        fifo_rd_r <= ~fifo_rd_r;
      if (push & ~pop)
        fifo_cnt_r <= fifo_cnt_r + 2'h1;
      else if (pop & ~push)
        fifo_cnt_r <= fifo_cnt_r - 2'h1;
    end
  end

  assign memory_buffer_o         = memory_buffer_reg;
  assign output_buffer_o         = output_buffer_reg;
  assign shift_count_mod6_o      = shift_count_mod6;
  assign char_count_mod7_o       = char_count_mod7;
  assign char_count_mod2_o       = char_count_mod2;
  assign card_group_count_mod4_o = card_group_count_mod4;
  assign second_shift_o          = second_r;

endmodule

/* File: row_column_shift_map.vh */
// constants for the row/column shift network
// Contract
// - one buffer-shift pulse drives both the character swap and the one-bit shift.
// - a lone buffer-shift pulse swaps low stages 1-8 with high stages 9-16.
// - two back-to-back pulses give a swap then a one-bit shift of the twelve data bits.
// - after the first shift stage 1 is X, 2-6 old 9-13, 7 old 15, 8 parity, 9-16 old 1-8.
// - after the second shift stage 1 is Y, 2-6 old 1-5, 7 old 7, 8 a second parity.
// - after the second shift stage 9 is X, 10-14 old 9-13, 15 old 15, 16 first parity.
// - every buffer-shift writes fresh parity to stage 8 from stage-1 input and stages 14, 16.
// - conversions shift six data bits, insert the control bit and insert parity each shift.
// - on output, buffer stage 14 moves to output stage 1 on the swap shift only.
// - on input, input stage 6 moves to buffer stage 1 on the one-bit shift only; with both side pulses the code also takes it into stage 1 on the swap shift.
// - with both side shifts stage 1 takes input stage 6; with output shift only, stage 6.
// - row-to-column runs only in the input phase, column-to-row only in the output phase.
// - a modulo-six shift counter advances as a shift counter on every shift pulse; the code steps it only on the pair-completing one-bit shift.
// - modulo-seven and modulo-two counters count 14 characters; a modulo-four picks group.
// - on column-to-row output every six shifted bits send a character to the punch buffer.
`ifndef ROW_COLUMN_SHIFT_MAP_VH
`define ROW_COLUMN_SHIFT_MAP_VH
`define MEM_BUF_W      16
`define SIDE_BUF_W     6
`define MEM_BUF_RST    16'h0000
`define SIDE_BUF_RST   6'h00
`define MOD6_RST       3'h0
`define MOD6_LAST      3'h4
`define MOD7_RST       3'h0
`define MOD7_LAST      3'h4
`define MOD4_LAST      2'h3
`define FIFO_DEPTH     2
`endif

/* File: row_column_shift_checker.sv */
// port-level assertions for the row/column shift network
module row_column_shift_checker (
  input wire logic        core_clk_i, sys_rst_i, mem_buf_shift_pulse_i,
  input wire logic        in_buf_shift_left_pulse_i, convert_i,
  input wire logic        out_buf_shift_left_pulse_i, output_phase_i,
  input wire logic        mem_load_i, char_ready_i, char_valid_o,
  input wire logic        shift_ready_o, second_shift_o,
  input wire logic [15:0] memory_buffer_o,
  input wire logic [5:0]  output_buffer_o
);
  timeunit 1ns; timeprecision 1ps;
  // a pulse only counts while the character buffer has room
  wire sh = mem_buf_shift_pulse_i & shift_ready_o;
  wire ip = in_buf_shift_left_pulse_i;
  wire op = out_buf_shift_left_pulse_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_swap; sh |=> memory_buffer_o[15:8] == $past(memory_buffer_o[7:0]);
  endproperty
  a_swap: assert property (p_swap) else $error("swap");
  property p_low; sh |=> memory_buffer_o[6:1] ==
    {$past(memory_buffer_o[14]), $past(memory_buffer_o[12:8])}; endproperty
  a_low: assert property (p_low) else $error("low half");
  property p_par; sh |=> memory_buffer_o[7] == ~(memory_buffer_o[0] ^
    $past(memory_buffer_o[13]) ^ $past(memory_buffer_o[15])); endproperty
  a_par: assert property (p_par) else $error("parity");
  property p_mb6; sh & op & !ip |=> memory_buffer_o[0] == $past(memory_buffer_o[5]);
  endproperty
  a_mb6: assert property (p_mb6) else $error("stage one");
  property p_ob; sh & op & !second_shift_o & convert_i & output_phase_i |=>
    output_buffer_o == {$past(output_buffer_o[4:0]), $past(memory_buffer_o[13])};
  endproperty
  a_ob: assert property (p_ob) else $error("out shift");
  property p_obh; !sh | second_shift_o |=> $stable(output_buffer_o); endproperty
  a_obh: assert property (p_obh) else $error("out hold");
  property p_pair; sh |=> second_shift_o != $past(second_shift_o); endproperty
  a_pair: assert property (p_pair) else $error("pairing");
  property p_hold; !sh & !mem_load_i |=> $stable(memory_buffer_o); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  cover property (sh & ip & op);
  cover property (mem_buf_shift_pulse_i & !shift_ready_o);
  cover property (char_valid_o & char_ready_i);
endmodule
bind row_column_shift_network row_column_shift_checker chk_i (.*);

/* File: char_sink.sv */
// receiver of the character stream, stalling at random
module char_sink (
  input  wire logic core_clk_i,
  input  wire logic char_valid_o,
  output logic      char_ready_i
);
  timeunit 1ns; timeprecision 1ps;
  int seed = 37;
  initial char_ready_i = 0;
  // random stalls let the two-entry buffer fill and refuse shifts
  always @(negedge core_clk_i) char_ready_i <= char_valid_o & 1'($random(seed));
endmodule

/* File: testbench.sv */
// self-checking bench for the row/column shift network
module testbench;
  timeunit 1ns; timeprecision 1ps;
  logic core_clk_i = 0, sys_rst_i = 1, mem_buf_shift_pulse_i = 0, s = 0;
  logic in_buf_shift_left_pulse_i = 0, out_buf_shift_left_pulse_i = 0;
  logic input_phase_i = 0, output_phase_i = 0, convert_i = 0;
  logic mem_load_i = 0, in_load_i = 0, char_ready_i, char_valid_o;
  logic shift_ready_o, char_count_mod2_o, second_shift_o;
  logic [15:0] mem_load_data_i = 0, memory_buffer_o, m = 0, mq[$];
  logic [5:0] in_load_data_i = 0, char_data_o, output_buffer_o;
  logic [5:0] o = 0, ib = 0, cq[$];
  logic [2:0] shift_count_mod6_o, char_count_mod7_o;
  logic [1:0] card_group_count_mod4_o;
  int mismatches = 0, comparisons = 0, seed = 37, k = 0, v, c = 0, g = 0;
  logic [8:0] nq[$];
  logic [2:0] seq6 [6] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h6, 3'h4};
  logic [2:0] seq7 [7] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h3, 3'h6, 3'h4};
  row_column_shift_network row_column_shift_network_i (.*);
  char_sink char_sink_i (.*);
  always #12.5 core_clk_i = ~core_clk_i;
  task cmp(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one buffer shift; a: input side pulse, b: output side pulse
  task shift(input logic a, b);
    logic sel;
    if (!shift_ready_o) begin
      in_load_i = 0;
      while (!shift_ready_o) @(negedge core_clk_i);
    end
    sel = a ? (b ? ib[5] : o[0]) : b & m[5];
    mem_buf_shift_pulse_i = 1;
    in_buf_shift_left_pulse_i = a;
    out_buf_shift_left_pulse_i = b;
    in_load_i = ~s;
    in_load_data_i = 6'($random(seed));
    @(posedge core_clk_i);
    if (s) k = (k + 1) % 6;
    if (s & k == 0 & convert_i & output_phase_i)
      cq.push_back({o[4:0], m[13]});
    if (s & k == 0) begin
      c = (c + 1) % 14;
      if (c == 0) g = (g + 1) % 4;
    end
    nq.push_back({seq6[k], seq7[c % 7], c >= 7, 2'(g)});
    if (b & ~s & convert_i & output_phase_i) o = {o[4:0], m[13]};
    if (~s) ib = in_load_data_i;
    else if (a & convert_i & input_phase_i) ib = {ib[4:0], 1'bx};
    m = {m[7:0], ~(sel ^ m[13] ^ m[15]), m[14], m[12:8], sel};
    s = ~s;
    mq.push_back(m);
    @(negedge core_clk_i);
  endtask
  // result watchers take the oldest expectation
  always @(negedge core_clk_i)
    if (mq.size()) cmp(memory_buffer_o, mq.pop_front());
  always @(negedge core_clk_i)
    if (nq.size())
      cmp({7'h00, shift_count_mod6_o, char_count_mod7_o, char_count_mod2_o,
           card_group_count_mod4_o}, {7'h00, nq.pop_front()});
  // look mid-cycle, once ready has settled and before the popping edge
  always @(negedge core_clk_i) begin
    #5;
    if (char_valid_o & char_ready_i)
      cmp({10'h000, char_data_o}, {10'h000, cq.pop_front()});
  end
  initial begin
    #500us;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (5) @(negedge core_clk_i);
    sys_rst_i = 0;
    for (int r = 0; r < 40; r++) begin
      mem_buf_shift_pulse_i = 0;
      mem_load_i = 1;
      mem_load_data_i = 16'($random(seed));
      {convert_i, input_phase_i} = 2'($random(seed));
      output_phase_i = ~input_phase_i;
      m = mem_load_data_i;
      @(negedge core_clk_i);
      mem_load_i = 0;
      repeat (12) begin
        v = $random(seed);
        shift(v[0], v[1]);
      end
      $display("test %0d done", r);
    end
    mem_buf_shift_pulse_i = 0;
    in_load_i = 0;
    repeat (30) @(negedge core_clk_i);
    stop_test;
  end
endmodule
